/* File: logic/alu_slice_pkg.sv */
// Constants, encodings and register map for the 8-bit arithmetic/logic slice
package alu_slice_pkg;

	// ****************************************************************
	// Register map (byte addresses, one aligned 32-bit word each)
	// ****************************************************************
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  ADDR_REGS0   = 8'h08;
	localparam logic [7:0]  ADDR_REGS1   = 8'h0C;
	localparam logic [7:0]  ADDR_STACK   = 8'h10;
	localparam logic [7:0]  ADDR_MEM     = 8'h14;

	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ****************************************************************
	// Control word fields
	// ****************************************************************
	localparam int          CTRL_OP_LSB  = 0;
	localparam int          CTRL_SEL_LSB = 4;
	localparam int          CTRL_IMM_LSB = 8;
	localparam int          CTRL_START   = 31;
	localparam int          MEM_IDX_LSB  = 8;

	// Flag byte layout
	localparam int          FLAG_CARRY   = 0;
	localparam int          FLAG_P       = 2;
	localparam int          FLAG_HALF    = 4;
	localparam int          FLAG_Z       = 6;
	localparam int          FLAG_S       = 7;

	// Register file indices; index 6 is an unnamed register, memory operands come from their own op codes
	localparam logic [2:0]  REG_B        = 3'h0;
	localparam logic [2:0]  REG_C        = 3'h1;
	localparam logic [2:0]  REG_D        = 3'h2;
	localparam logic [2:0]  REG_E        = 3'h3;
	localparam logic [2:0]  REG_H        = 3'h4;
	localparam logic [2:0]  REG_L        = 3'h5;
	localparam logic [2:0]  REG_A        = 3'h7;

	localparam int          MEM_IDX_W    = 4;
	localparam int          MEM_DEPTH    = 16;

	// Decimal adjust constants
	localparam logic [3:0]  BCD_LIMIT    = 4'h9;
	localparam logic [8:0]  LOW_ADJUST   = 9'h006;
	localparam logic [8:0]  HIGH_ADJUST  = 9'h060;

	// ****************************************************************
	// Execution lengths in clock cycles (one state per cycle)
	// ****************************************************************
	localparam logic [3:0]  STATES_SHORT = 4'h4;
	localparam logic [3:0]  STATES_PAIR  = 4'h6;
	localparam logic [3:0]  STATES_TWO   = 4'h7;
	localparam logic [3:0]  STATES_THREE = 4'hA;

	typedef enum logic [3:0] {
		decrement_byte_op      = 4'h0,
		decrement_mem_op       = 4'h1,
		increment_pair_op      = 4'h2,
		decrement_pair_op      = 4'h3,
		pair_add_to_pointer_op = 4'h4,
		decimal_adjust_op      = 4'h5,
		and_operand_op         = 4'h6,
		and_mem_op             = 4'h7,
		and_immediate_op       = 4'h8,
		xor_operand_op         = 4'h9,
		xor_immediate_op       = 4'hA,
		or_operand_op          = 4'hB,
		or_immediate_op        = 4'hC,
		compare_operand_op     = 4'hD,
		compare_immediate_op   = 4'hE,
		compare_mem_op         = 4'hF
	} op_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} state_type;

endpackage

/* File: logic/alu_slice.sv */
// Arithmetic/logic slice with register file, small memory and AXI4-Lite access
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Register decrement subtracts one, updates zero sign parity half carry, keeps carry.
// - Memory decrement rewrites byte at pointer pair minus one, carry untouched.
// - Pair increment adds one over sixteen bits, no flags, six states.
// - Pair decrement subtracts one over sixteen bits, no flags changed.
// - Pair add into pointer pair sets carry from bit 15 only, ten states.
// - Decimal adjust adds six when low nibble over nine or half carry.
// - Then adds six to high nibble when over nine or carry; all flags.
// - Logical operations update all five flags; zero, sign and parity from the result.
// - AND stores into accumulator, clears carry, sets half carry.
// - XOR stores into accumulator, clears carry and half carry.
// - OR stores into accumulator, clears carry and half carry.
// - Compare subtracts only for flags; accumulator keeps its value.
// - Compare sets zero on equal, carry when accumulator is less.
// - Immediate forms use the instruction second byte, seven states.
// - Immediate AND combines the byte following the operation code.
// - Memory forms fetch the operand through the pointer pair.
module alu_slice
	import alu_slice_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] makeFlags(input logic [7:0] res, input logic carry,
		input logic half);
		logic [7:0] f;
		f          = 8'h00;
		f[FLAG_Z]  = (res == 8'h00);
		f[FLAG_S]  = res[7];
		f[FLAG_P]  = ~^res;
		f[FLAG_HALF]  = half;
		f[FLAG_CARRY] = carry;
		return f;
	endfunction

	// Subtract as add of the complement; half carry is the carry out of bit 3
	function automatic logic [9:0] subtract(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] sum;
		logic [4:0] low;
		sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {low[4], ~sum[8], sum[7:0]};  // {ac, borrow, diff}
	endfunction

	function automatic logic [31:0] mergeStrobe(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]            regs_q [8];
	logic [7:0]            regs_d [8];
	logic [7:0]            mem_q  [MEM_DEPTH];
	logic [7:0]            mem_d  [MEM_DEPTH];
	logic [7:0]            flags_q, flags_d;
	logic [15:0]           sp_q, sp_d;
	logic [MEM_IDX_W-1:0]  memIdx_q, memIdx_d;
	state_type             state_q, state_d;
	logic [3:0]            count_q, count_d;
	op_type                op_q, op_d;
	logic [2:0]            sel_q, sel_d;
	logic [7:0]            imm_q, imm_d;
	logic                  awready_q, awready_d, wready_q, wready_d;
	logic                  awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [ADDR_W-1:0]     awAddr_q, awAddr_d;
	logic [31:0]           wData_q, wData_d;
	logic [3:0]            wStrb_q, wStrb_d;
	logic                  bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]           rdata_q, rdata_d;

	logic [15:0]           hl, pairVal, pairRes;
	logic [16:0]           pairSum;
	logic [MEM_IDX_W-1:0]  hlIdx;
	logic [7:0]            acc, operand, logicRes;
	logic [9:0]            subRes;
	logic [8:0]            lowStep, daaRes;
	logic                  lowAdj, highAdj, busy;
	logic [31:0]           readWord, curWord;
	logic                  readHit, writeHit;

	// ****************************************************************
	// Operand selection and datapath
	// ****************************************************************
	always_comb begin
		hl      = {regs_q[REG_H], regs_q[REG_L]};
		hlIdx   = hl[MEM_IDX_W-1:0];
		acc     = regs_q[REG_A];
		busy    = (state_q == ST_RUN);
		case (sel_q[1:0])
			2'h0:    pairVal = {regs_q[REG_B], regs_q[REG_C]};
			2'h1:    pairVal = {regs_q[REG_D], regs_q[REG_E]};
			2'h2:    pairVal = hl;
			default: pairVal = sp_q;
		endcase
		case (op_q)
			decrement_mem_op, and_mem_op, compare_mem_op: begin
				operand = mem_q[hlIdx];
			end
			and_immediate_op, xor_immediate_op, or_immediate_op,
			compare_immediate_op: begin
				operand = imm_q;
			end
			default: operand = regs_q[sel_q];
		endcase
		case (op_q)
			and_operand_op, and_mem_op, and_immediate_op: logicRes = acc & operand;
			xor_operand_op, xor_immediate_op:             logicRes = acc ^ operand;
			default:                                      logicRes = acc | operand;
		endcase
		case (op_q)
			decrement_byte_op, decrement_mem_op: subRes = subtract(operand, 8'h01);
			default:                             subRes = subtract(acc, operand);
		endcase
		pairSum = {1'b0, hl} + {1'b0, pairVal};
		pairRes = (op_q == increment_pair_op) ? pairVal + 16'h0001 : pairVal - 16'h0001;
		lowAdj  = (acc[3:0] > BCD_LIMIT) || flags_q[FLAG_HALF];
		lowStep = {1'b0, acc} + (lowAdj ? LOW_ADJUST : 9'h000);
		highAdj = (lowStep[7:4] > BCD_LIMIT) || flags_q[FLAG_CARRY] || lowStep[8];
		daaRes  = {1'b0, lowStep[7:0]} + (highAdj ? HIGH_ADJUST : 9'h000);
	end

	// ****************************************************************
	// Register read mux
	// ****************************************************************
	always_comb begin
		readHit  = 1'b1;
		readWord = 32'h0000_0000;
		case (araddr)
			ADDR_CTRL:   readWord = {24'h00_0000, sel_q, 1'b0, op_q} | 
				{16'h0000, imm_q, 8'h00};
			ADDR_STATUS: readWord = {16'h0000, flags_q, 7'h00, busy};
			ADDR_REGS0:  readWord = {regs_q[REG_B], regs_q[REG_C], regs_q[REG_D],
				regs_q[REG_E]};
			ADDR_REGS1:  readWord = {regs_q[REG_H], regs_q[REG_L], regs_q[REG_A], flags_q};
			ADDR_STACK:  readWord = {16'h0000, sp_q};
			ADDR_MEM:    readWord = {20'h0_0000, memIdx_q, mem_q[memIdx_q]};
			default:     readHit  = 1'b0;
		endcase
	end

	// ****************************************************************
	// Next state: bus slave, register writes, execution
	// ****************************************************************
	always_comb begin
		regs_d    = regs_q;
		mem_d     = mem_q;
		flags_d   = flags_q;
		sp_d      = sp_q;
		memIdx_d  = memIdx_q;
		state_d   = state_q;
		count_d   = count_q;
		op_d      = op_q;
		sel_d     = sel_q;
		imm_d     = imm_q;
		awready_d = awready_q;
		wready_d  = wready_q;
		awHeld_d  = awHeld_q;
		wHeld_d   = wHeld_q;
		awAddr_d  = awAddr_q;
		wData_d   = wData_q;
		wStrb_d   = wStrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		writeHit  = 1'b1;
		curWord   = 32'h0000_0000;

		if (awvalid && awready_q) begin
			awHeld_d  = 1'b1;
			awAddr_d  = awaddr;
			awready_d = 1'b0;
		end
		if (wvalid && wready_q) begin
			wHeld_d  = 1'b1;
			wData_d  = wdata;
			wStrb_d  = wstrb;
			wready_d = 1'b0;
		end

		// Software writes are dropped while an operation runs so operands stay stable
		if (awHeld_q && wHeld_q && !bvalid_q) begin
			case (awAddr_q)
				ADDR_CTRL: begin
					curWord = mergeStrobe(32'h0000_0000, wData_q, wStrb_q);
					if (!busy && curWord[CTRL_START]) begin
						op_d    = op_type'(curWord[CTRL_OP_LSB +: 4]);
						sel_d   = curWord[CTRL_SEL_LSB +: 3];
						imm_d   = curWord[CTRL_IMM_LSB +: 8];
						state_d = ST_RUN;
						case (op_type'(curWord[CTRL_OP_LSB +: 4]))
							decrement_byte_op, decimal_adjust_op, and_operand_op,
							xor_operand_op, or_operand_op,
							compare_operand_op:    count_d = STATES_SHORT;
							increment_pair_op,
							decrement_pair_op:     count_d = STATES_PAIR;
							decrement_mem_op,
							pair_add_to_pointer_op: count_d = STATES_THREE;
							default:               count_d = STATES_TWO;
						endcase
					end
				end
				ADDR_REGS0: begin
					curWord = mergeStrobe({regs_q[REG_B], regs_q[REG_C], regs_q[REG_D],
						regs_q[REG_E]}, wData_q, wStrb_q);
					if (!busy) begin
						{regs_d[REG_B], regs_d[REG_C], regs_d[REG_D], regs_d[REG_E]} = curWord;
					end
				end
				ADDR_REGS1: begin
					curWord = mergeStrobe({regs_q[REG_H], regs_q[REG_L], regs_q[REG_A],
						flags_q}, wData_q, wStrb_q);
					if (!busy) begin
						{regs_d[REG_H], regs_d[REG_L], regs_d[REG_A], flags_d} = curWord;
					end
				end
				ADDR_STACK: begin
					curWord = mergeStrobe({16'h0000, sp_q}, wData_q, wStrb_q);
					if (!busy) begin
						sp_d = curWord[15:0];
					end
				end
				ADDR_MEM: begin
					curWord = mergeStrobe({20'h0_0000, memIdx_q, mem_q[memIdx_q]},
						wData_q, wStrb_q);
					if (!busy) begin
						memIdx_d = curWord[MEM_IDX_LSB +: MEM_IDX_W];
						mem_d[curWord[MEM_IDX_LSB +: MEM_IDX_W]] = curWord[7:0];
					end
				end
				ADDR_STATUS: writeHit = 1'b1;
				default:     writeHit = 1'b0;
			endcase
			bvalid_d = 1'b1;
			bresp_d  = writeHit ? RESP_OKAY : RESP_SLVERR;
			awHeld_d = 1'b0;
			wHeld_d  = 1'b0;
		end
		if (bvalid_q && bready) begin
			bvalid_d  = 1'b0;
			awready_d = 1'b1;
			wready_d  = 1'b1;
		end

		if (arvalid && arready_q) begin
			rdata_d   = readWord;
			rresp_d   = readHit ? RESP_OKAY : RESP_SLVERR;
			rvalid_d  = 1'b1;
			arready_d = 1'b0;
		end
		if (rvalid_q && rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end

		// Results land in the last state of the operation
		case (state_q)
			ST_IDLE: count_d = count_d;
			ST_RUN: begin
				count_d = count_q - 4'h1;
				if (count_q == 4'h1) begin
					state_d = ST_IDLE;
					case (op_q)
						decrement_byte_op: begin
							regs_d[sel_q] = subRes[7:0];
							flags_d = makeFlags(subRes[7:0], flags_q[FLAG_CARRY], subRes[9]);
						end
						decrement_mem_op: begin
							mem_d[hlIdx] = subRes[7:0];
							flags_d = makeFlags(subRes[7:0], flags_q[FLAG_CARRY], subRes[9]);
						end
						increment_pair_op, decrement_pair_op: begin
							case (sel_q[1:0])
								2'h0:    {regs_d[REG_B], regs_d[REG_C]} = pairRes;
								2'h1:    {regs_d[REG_D], regs_d[REG_E]} = pairRes;
								2'h2:    {regs_d[REG_H], regs_d[REG_L]} = pairRes;
								default: sp_d = pairRes;
							endcase
						end
						pair_add_to_pointer_op: begin
							{regs_d[REG_H], regs_d[REG_L]} = pairSum[15:0];
							flags_d[FLAG_CARRY] = pairSum[16];
						end
						decimal_adjust_op: begin
							regs_d[REG_A] = daaRes[7:0];
							flags_d = makeFlags(daaRes[7:0],
								flags_q[FLAG_CARRY] | lowStep[8] | daaRes[8],
								lowStep[4] ^ acc[4]);
						end
						and_operand_op, and_mem_op, and_immediate_op: begin
							regs_d[REG_A] = logicRes;
							flags_d = makeFlags(logicRes, 1'b0, 1'b1);
						end
						xor_operand_op, xor_immediate_op: begin
							regs_d[REG_A] = logicRes;
							flags_d = makeFlags(logicRes, 1'b0, 1'b0);
						end
						or_operand_op, or_immediate_op: begin
							regs_d[REG_A] = logicRes;
							flags_d = makeFlags(logicRes, 1'b0, 1'b0);
						end
						default: begin
							// Accumulator left alone; borrow is carry
							flags_d = makeFlags(subRes[7:0], subRes[8], subRes[9]);
						end
					endcase
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			regs_q    <= '{default: 8'h00};
			mem_q     <= '{default: 8'h00};
			flags_q   <= 8'h00;
			sp_q      <= 16'h0000;
			memIdx_q  <= '0;
			state_q   <= ST_IDLE;
			count_q   <= 4'h0;
			op_q      <= decrement_byte_op;
			sel_q     <= 3'h0;
			imm_q     <= 8'h00;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			awAddr_q  <= '0;
			wData_q   <= 32'h0000_0000;
			wStrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else begin
			regs_q    <= regs_d;
			mem_q     <= mem_d;
			flags_q   <= flags_d;
			sp_q      <= sp_d;
			memIdx_q  <= memIdx_d;
			state_q   <= state_d;
			count_q   <= count_d;
			op_q      <= op_d;
			sel_q     <= sel_d;
			imm_q     <= imm_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			awHeld_q  <= awHeld_d;
			wHeld_q   <= wHeld_d;
			awAddr_q  <= awAddr_d;
			wData_q   <= wData_d;
			wStrb_q   <= wStrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;

endmodule // alu_slice

`default_nettype wire

/* File: bench/alu_slice_props.sv */
// Register bus protocol checker for the arithmetic/logic slice
`timescale 1ns/100ps
`default_nettype none
module alu_slice_props
	import alu_slice_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic [31:0]       wdata,
	input wire logic [3:0]        wstrb,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready
);
	// ****************************************************************
	// Handshake properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_rd_answer; arvalid && arready |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_ar_block; rvalid |-> !arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read address open while answering");
	property p_aw_block; bvalid |-> !awready && !wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write channels open while answering");
	property p_wr_answer; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_b_release; bvalid && bready |=> !bvalid && awready && wready; endproperty
	a_b_release: assert property (p_b_release) else $error("write response not released");
	property p_r_release; rvalid && rready |=> !rvalid && arready; endproperty
	a_r_release: assert property (p_r_release) else $error("read data not released");
	// Unmapped reads must not leak stale data
	property p_slverr_zero; rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0000_0000; endproperty
	a_slverr_zero: assert property (p_slverr_zero) else $error("error read carries data");
endmodule // alu_slice_props

bind alu_slice alu_slice_props chk_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking testbench for the arithmetic/logic slice
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import alu_slice_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0]       wdata = '0;
	logic [3:0]        wstrb = '0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	int                err_count = 0;
	int                n_compared = 0;
	int                lastPolls = 0;

	always #20 clk = ~clk;

	alu_slice dut_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ****************************************************************
	// Bus and compare helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			// Ready one clock late, so the slave must hold its answer
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end else if (bvalid) begin
				bready <= 1'b1;
			end
		end while (!done && n < 100);
		chk("write handshake", 32'h0000_0001, {31'h0, done});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic done;
		n = 0;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end else if (rvalid) begin
				rready <= 1'b1;
			end
		end while (!done && n < 100);
		chk("read handshake", 32'h0000_0001, {31'h0, done});
	endtask

	task automatic load(input logic [31:0] r0, input logic [31:0] r1);
		logic [1:0] r;
		wr(ADDR_REGS0, r0, 4'hF, r);
		wr(ADDR_REGS1, r1, 4'hF, r);
	endtask

	task automatic expect_regs(input logic [31:0] r0, input logic [31:0] r1);
		logic [31:0] d;
		logic [1:0]  r;
		rd(ADDR_REGS0, d, r);
		chk("regs0", r0, d);
		rd(ADDR_REGS1, d, r);
		chk("regs1", r1, d);
	endtask

	task automatic start(input op_type op, input logic [2:0] sel, input logic [7:0] imm);
		logic [31:0] d;
		logic [1:0]  r;
		d = '0;
		d[CTRL_OP_LSB +: 4] = op;
		d[CTRL_SEL_LSB +: 3] = sel;
		d[CTRL_IMM_LSB +: 8] = imm;
		d[CTRL_START] = 1'b1;
		wr(ADDR_CTRL, d, 4'hF, r);
	endtask

	// A poll spans three clocks: 4, 6 or 7, and 10 states give 1, 2 and 3 busy polls
	task automatic wait_idle(output int polls);
		logic [31:0] d;
		logic [1:0]  r;
		polls = 0;
		rd(ADDR_STATUS, d, r);
		while (d[0] === 1'b1 && polls < 20) begin
			polls++;
			rd(ADDR_STATUS, d, r);
		end
		chk("busy cleared", 32'h0000_0000, {31'h0, d[0]});
	endtask

	task automatic run(input op_type op, input logic [2:0] sel, input logic [7:0] imm);
		start(op, sel, imm);
		wait_idle(lastPolls);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rd(ADDR_STATUS, d, r);
		chk("status", 32'h0000_0000, d);
		expect_regs(32'h0000_0000, 32'h0000_0000);
		$display("test reset finished");
	endtask

	task automatic t_dec;
		load(32'h1000_0100, 32'h0000_0001);
		run(decrement_byte_op, REG_B, 8'h00);
		chk("register op polls", 32'h0000_0001, lastPolls);
		expect_regs(32'h0F00_0100, 32'h0000_0005);
		run(decrement_byte_op, REG_C, 8'h00);
		expect_regs(32'h0FFF_0100, 32'h0000_0085);
		run(decrement_byte_op, REG_D, 8'h00);
		expect_regs(32'h0FFF_0000, 32'h0000_0055);
		$display("test register decrement finished");
	endtask

	task automatic t_dec_mem;
		logic [31:0] d;
		logic [1:0]  r;
		load(32'h0000_0000, 32'h0003_0001);
		wr(ADDR_MEM, 32'h0000_0300, 4'hF, r);
		run(decrement_mem_op, 3'h0, 8'h00);
		rd(ADDR_MEM, d, r);
		chk("memory byte", 32'h0000_00FF, {24'h0, d[7:0]});
		expect_regs(32'h0000_0000, 32'h0003_0085);
		$display("test memory decrement finished");
	endtask

	task automatic t_pairs;
		logic [31:0] d;
		logic [1:0]  r;
		load(32'h00FF_0000, 32'h8001_00D4);
		run(increment_pair_op, 3'h0, 8'h00);
		chk("pair op polls", 32'h0000_0002, lastPolls);
		run(decrement_pair_op, 3'h1, 8'h00);
		expect_regs(32'h0100_FFFF, 32'h8001_00D4);
		run(pair_add_to_pointer_op, 3'h1, 8'h00);
		chk("pair add polls", 32'h0000_0003, lastPolls);
		expect_regs(32'h0100_FFFF, 32'h8000_00D5);
		run(pair_add_to_pointer_op, 3'h0, 8'h00);
		expect_regs(32'h0100_FFFF, 32'h8100_00D4);
		run(decrement_pair_op, 3'h3, 8'h00);
		rd(ADDR_STACK, d, r);
		chk("stack pair", 32'h0000_FFFF, d);
		$display("test register pairs finished");
	endtask

	task automatic t_daa;
		load(32'h0000_0000, 32'h0000_9B00);
		run(decimal_adjust_op, 3'h0, 8'h00);
		expect_regs(32'h0000_0000, 32'h0000_0111);
		load(32'h0000_0000, 32'h0000_2001);
		run(decimal_adjust_op, 3'h0, 8'h00);
		expect_regs(32'h0000_0000, 32'h0000_8081);
		$display("test decimal adjust finished");
	endtask

	task automatic t_logic;
		op_type      ops[7] = '{and_operand_op, xor_immediate_op, or_operand_op,
			xor_operand_op, or_immediate_op, and_immediate_op, and_mem_op};
		logic [7:0]  imms[7] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h81, 8'hC1, 8'h00};
		logic [15:0] res[7] = '{16'h3014, 16'h0044, 16'h3C04, 16'h0044, 16'h8184,
			16'h8194, 16'h0110};
		logic [1:0]  r;
		load(32'h3C00_0000, 32'h0005_F001);
		wr(ADDR_MEM, 32'h0000_0555, 4'hF, r);
		for (int i = 0; i < 7; i++) begin
			run(ops[i], REG_B, imms[i]);
			expect_regs(32'h3C00_0000, {16'h0005, res[i]});
		end
		$display("test logical group finished");
	endtask

	task automatic t_compare;
		logic [1:0] r;
		load(32'h4000_0000, 32'h0005_4000);
		wr(ADDR_MEM, 32'h0000_053F, 4'hF, r);
		run(compare_operand_op, REG_B, 8'h00);
		expect_regs(32'h4000_0000, 32'h0005_4054);
		run(compare_immediate_op, 3'h0, 8'h41);
		chk("immediate op polls", 32'h0000_0002, lastPolls);
		expect_regs(32'h4000_0000, 32'h0005_4085);
		run(compare_mem_op, 3'h0, 8'h00);
		expect_regs(32'h4000_0000, 32'h0005_4000);
		$display("test compare finished");
	endtask

	// Unmapped places, lane merge, writes dropped while busy
	task automatic t_bus;
		logic [31:0] d;
		logic [1:0]  r;
		int          f;
		rd(8'h18, d, r);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(8'h40, 32'h1234_5678, 4'hF, r);
		chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(ADDR_REGS0, 32'hAAAA_AA5A, 4'h1, r);
		wr(ADDR_REGS1, 32'h0001_0000, 4'hF, r);
		start(pair_add_to_pointer_op, 3'h2, 8'h00);
		wr(ADDR_REGS1, 32'hFFFF_FFFF, 4'hF, r);
		chk("busy write resp", {30'h0, RESP_OKAY}, {30'h0, r});
		wait_idle(f);
		expect_regs(32'h4000_005A, 32'h0002_0000);
		wr(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, r);
		rd(ADDR_STATUS, d, r);
		chk("status", 32'h0000_0000, d);
		$display("test bus finished");
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#2_000_000;
		err_count++;
		stop_test;
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_dec;
		t_dec_mem;
		t_pairs;
		t_daa;
		t_logic;
		t_compare;
		t_bus;
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
